// File: rtl/load_switch_seq.sv
// Summary of operation
// RULE1: enable low turns the switch off and enters low-power shutdown.
// RULE2: enable high arms protections; switch turns on only without a fault.
// RULE3: supply lockout holds the switch off regardless of enable.
// RULE4: switch on only with supply good, enable high and no fault.
// RULE5: normal mode waits 0.75 ms after enable, then ramps over 1.5 ms.
// RULE6: normal turn-on applies 0.8 A soft limit for a 7 ms window.
// RULE7: output above 40 percent at window end enters normal programmed limit.
// RULE8: output below 40 percent at window end turns off and retries.
// RULE9: short-circuit shutdown waits 70 ms before the next start attempt.
// RULE10: fast mode cuts delay to 36 us and rise to under 100 us.
// RULE11: fast mode with output below input has switch on within 150 us.
// RULE12: output above input keeps switch off; 15 us after it falls, on.
// RULE13: fast mode blanks the programmed limit for 370 us after enable rise.
// RULE14: current-limit fault drives the flag low after 8 ms.
// RULE15: flag stays asserted 17 ms after any fault recovers.
// RULE16: while on, reverse-block is entered and left automatically.
// RULE17: flag low for limit, overcurrent, short and thermal; never for reverse.
// RULE18: overcurrent turns the switch off at once, then hiccup and soft-start.
// RULE19: after thermal clears: hiccup, soft-start, then flag release.
// RULE20: all delays from one time base; enable and fast-on synchronised.
// RULE21: controller settles fast-on before enable and treats low flag as fault.
`timescale 1ns/100ps

module load_switch_seq
	import load_switch_pkg::*;
#(
	parameter tick_cnt_t DEB_TICKS       = tick_cnt_t'(`DEB_TICKS),
	parameter tick_cnt_t RISE_TICKS      = tick_cnt_t'(`RISE_TICKS),
	parameter tick_cnt_t SS_TICKS        = tick_cnt_t'(`SS_TICKS),
	parameter tick_cnt_t HICCUP_TICKS    = tick_cnt_t'(`HICCUP_TICKS),
	parameter tick_cnt_t BLANK_TICKS     = tick_cnt_t'(`BLANK_TICKS),
	parameter tick_cnt_t FLT_DELAY_TICKS = tick_cnt_t'(`FLT_DELAY_TICKS),
	parameter tick_cnt_t FLT_RECOV_TICKS = tick_cnt_t'(`FLT_RECOV_TICKS)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        enable,
	input  wire logic        fast_on,
	input  wire logic        supply_lockout,
	input  wire logic        out_below_40pct,
	input  wire logic        out_above_in,
	input  wire logic        limit_active,
	input  wire logic        overcurrent_trip,
	input  wire logic        thermal_trip,
	input  wire logic        fault_flag_n_i,
	output logic             fault_flag_n_o,
	output logic             fault_flag_oe,
	output logic             switch_on,
	output logic             ramp_active,
	output logic             soft_limit_en,
	output logic             prog_limit_en,
	output logic             low_power
);

	localparam tick_cnt_t FAST_DEB_TICKS  = tick_cnt_t'(`FAST_DEB_TICKS);
	localparam tick_cnt_t FAST_RISE_TICKS = tick_cnt_t'(`FAST_RISE_TICKS);
	localparam tick_cnt_t RCP_TICKS       = tick_cnt_t'(`RCP_TICKS);
	localparam logic [5:0] TICK_LAST      = 6'(`TICK_DIV_CYCLES - 1);

	seq_state_t  state_q;
	seq_state_t  state_d;
	logic        ld;
	tick_cnt_t   ld_val;
	logic [5:0]  div_q;
	logic        tick_q;
	logic [1:0]  en_sync_q;
	logic [1:0]  fast_sync_q;
	logic        en_s;
	logic        fast_s;
	logic        en_prev_q;
	logic        hold_off_q;
	logic        run_ok;
	logic        fast_mode_q;
	tick_cnt_t   blank_q;
	logic        hard_fault_q;
	tick_cnt_t   clp_cnt_q;
	logic        clp_fault_q;
	tick_cnt_t   recov_q;
	logic        flag_on_q;
	logic        flag_lvl_q;
	logic        switch_q;
	logic        ramp_q;
	logic        soft_q;
	logic        prog_q;
	logic        lowp_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        access;
	logic [31:0] status_word;

	timer_if tmr_bus ();

	seq_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tmr     (tmr_bus.timer)
	);

	// ==================================================
	// time base and input synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == TICK_LAST); // [RULE20]
			div_q  <= (div_q == TICK_LAST) ? 6'h00 : div_q + 6'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_sync_q   <= 2'h0;
			fast_sync_q <= 2'h0;
			en_prev_q   <= 1'b0;
		end else begin
			en_sync_q   <= {en_sync_q[0], enable}; // [RULE20]
			fast_sync_q <= {fast_sync_q[0], fast_on}; // [RULE20]
			en_prev_q   <= en_s;
		end
	end

	assign en_s   = en_sync_q[1];
	assign fast_s = fast_sync_q[1];
	// software hold acts like a low enable
	assign run_ok = en_s && !supply_lockout && !hold_off_q; // [RULE3] [RULE4]

	// ==================================================
	// sequencer
	always_comb begin
		state_d = state_q;
		ld      = 1'b0;
		ld_val  = '0;
		if (!run_ok) begin
			state_d = ST_OFF; // [RULE1] [RULE3]
		end else if (thermal_trip) begin
			state_d = ST_THERMAL; // [RULE2] [RULE4]
		end else begin
			unique case (state_q)
				ST_OFF: begin
					state_d = ST_DEBOUNCE;
					ld      = 1'b1;
					ld_val  = fast_s ? FAST_DEB_TICKS : DEB_TICKS; // [RULE5] [RULE10] [RULE21]
				end
				ST_DEBOUNCE: begin
					if (tmr_bus.done && out_above_in) begin
						state_d = ST_REVERSE; // [RULE12]
						ld      = 1'b1;
						ld_val  = RCP_TICKS;
					end else if (tmr_bus.done) begin
						state_d = ST_RAMP; // [RULE11]
						ld      = 1'b1;
						ld_val  = fast_mode_q ? FAST_RISE_TICKS : SS_TICKS; // [RULE6] [RULE10]
					end
				end
				ST_RAMP: begin
					if (overcurrent_trip) begin
						state_d = ST_HICCUP; // [RULE18]
						ld      = 1'b1;
						ld_val  = HICCUP_TICKS;
					end else if (tmr_bus.done && !fast_mode_q && out_below_40pct) begin
						state_d = ST_HICCUP; // [RULE8] [RULE9]
						ld      = 1'b1;
						ld_val  = HICCUP_TICKS;
					end else if (tmr_bus.done) begin
						state_d = ST_ON; // [RULE7]
					end
				end
				ST_ON: begin
					// a sag below 40 percent with the switch on is treated as a short
					if (overcurrent_trip || out_below_40pct) begin
						state_d = ST_HICCUP; // [RULE18]
						ld      = 1'b1;
						ld_val  = HICCUP_TICKS;
					end else if (out_above_in) begin
						state_d = ST_REVERSE; // [RULE16]
						ld      = 1'b1;
						ld_val  = RCP_TICKS;
					end
				end
				ST_REVERSE: begin
					if (out_above_in) begin
						ld     = 1'b1; // [RULE12]
						ld_val = RCP_TICKS;
					end else if (tmr_bus.done) begin
						state_d = ST_ON; // [RULE12] [RULE16]
					end
				end
				ST_HICCUP: begin
					if (tmr_bus.done) begin
						state_d = ST_RAMP; // [RULE9] [RULE18]
						ld      = 1'b1;
						ld_val  = SS_TICKS;
					end
				end
				ST_THERMAL: begin
					state_d = ST_HICCUP; // [RULE19]
					ld      = 1'b1;
					ld_val  = HICCUP_TICKS;
				end
				default: begin
					state_d = ST_OFF;
				end
			endcase
		end
	end

	assign tmr_bus.load     = ld;
	assign tmr_bus.load_val = ld_val;
	assign tmr_bus.tick     = tick_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// retries always use the slow soft-start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_mode_q <= 1'b0;
		end else if (state_q == ST_OFF && state_d == ST_DEBOUNCE) begin
			fast_mode_q <= fast_s; // [RULE10]
		end else if (state_q == ST_HICCUP && state_d == ST_RAMP) begin
			fast_mode_q <= 1'b0; // [RULE18]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_q <= '0;
		end else if (en_s && !en_prev_q && fast_s) begin
			blank_q <= BLANK_TICKS; // [RULE13]
		end else if (tick_q && blank_q != '0) begin
			blank_q <= blank_q - 1'b1;
		end
	end

	// ==================================================
	// switch controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_q <= 1'b0;
			ramp_q   <= 1'b0;
			soft_q   <= 1'b0;
			prog_q   <= 1'b0;
			lowp_q   <= 1'b1;
		end else begin
			switch_q <= (state_q == ST_RAMP) || (state_q == ST_ON); // [RULE4]
			ramp_q   <= (state_q == ST_RAMP) && (fast_mode_q || tmr_bus.cnt > SS_TICKS - RISE_TICKS); // [RULE5]
			soft_q   <= (state_q == ST_RAMP) && !fast_mode_q; // [RULE6]
			prog_q   <= ((state_q == ST_ON) || (state_q == ST_RAMP && fast_mode_q))
				&& blank_q == '0; // [RULE7] [RULE13]
			lowp_q   <= (state_q == ST_OFF); // [RULE1]
		end
	end

	// ==================================================
	// fault flag
	// trip is a set and wins over the clear of the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hard_fault_q <= 1'b0;
		end else if (state_d == ST_THERMAL || (state_d == ST_HICCUP && state_q != ST_THERMAL
			&& state_q != ST_HICCUP)) begin
			hard_fault_q <= 1'b1; // [RULE17] [RULE18]
		end else if ((state_q == ST_RAMP && state_d == ST_ON) || !run_ok) begin
			hard_fault_q <= 1'b0; // [RULE19]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clp_cnt_q   <= '0;
			clp_fault_q <= 1'b0;
		end else if (!(limit_active && prog_q)) begin
			clp_cnt_q   <= '0;
			clp_fault_q <= 1'b0;
		end else if (clp_cnt_q == FLT_DELAY_TICKS) begin
			clp_fault_q <= 1'b1; // [RULE14]
		end else if (tick_q) begin
			clp_cnt_q <= clp_cnt_q + 1'b1;
		end
	end

	// recovery hold keeps the flag from toggling between fault kinds
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_on_q  <= 1'b0;
			flag_lvl_q <= 1'b1;
			recov_q    <= '0;
		end else if (hard_fault_q || clp_fault_q) begin
			flag_on_q  <= 1'b1; // [RULE17]
			flag_lvl_q <= 1'b0;
			recov_q    <= '0;
		end else if (flag_on_q && recov_q == FLT_RECOV_TICKS) begin
			flag_on_q  <= 1'b0; // [RULE15]
			flag_lvl_q <= 1'b1;
		end else if (flag_on_q && tick_q) begin
			recov_q <= recov_q + 1'b1;
		end
	end

	// ==================================================
	// apb slave, one wait state
	assign access = psel && penable;

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`ST_STATE_LSB +: 3] = state_q;
		status_word[`ST_SWITCH_BIT]     = switch_q;
		status_word[`ST_HARD_BIT]       = hard_fault_q;
		status_word[`ST_CLP_BIT]        = clp_fault_q;
		status_word[`ST_FLAG_BIT]       = flag_on_q;
		status_word[`ST_PIN_BIT]        = fault_flag_n_i;
		status_word[`ST_FAST_BIT]       = fast_mode_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= access && !pready_q;
			if (access && !pready_q) begin
				pslverr_q <= (paddr != `CTRL_OFFSET) && (paddr != `STATUS_OFFSET);
				if (paddr == `CTRL_OFFSET) begin
					prdata_q <= {31'h0000_0000, hold_off_q};
				end else if (paddr == `STATUS_OFFSET) begin
					prdata_q <= status_word;
				end else begin
					prdata_q <= 32'h0000_0000;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_off_q <= `CTRL_RESET;
		end else if (access && pready_q && pwrite && paddr == `CTRL_OFFSET) begin
			hold_off_q <= pwdata[`CTRL_HOLD_BIT];
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign fault_flag_n_o = flag_lvl_q;
	assign fault_flag_oe  = flag_on_q;
	assign switch_on      = switch_q;
	assign ramp_active    = ramp_q;
	assign soft_limit_en  = soft_q;
	assign prog_limit_en  = prog_q;
	assign low_power      = lowp_q;

	// ==================================================
	// checks
	a_lockout_forces_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
		supply_lockout |-> ##2 !switch_q) else $error("switch on under supply lockout");

	a_enable_low_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
		!en_s |-> ##2 (!switch_q && lowp_q)) else $error("no shutdown with enable low");

	a_switch_needs_all: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
		switch_q |-> ($past(run_ok, 2) && !$past(thermal_trip, 2))) else $error("switch on without conditions");

	a_short_to_hiccup: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
		(state_q == ST_RAMP && !fast_mode_q && tmr_bus.done && out_below_40pct && run_ok
		&& !thermal_trip && !overcurrent_trip) |=> (state_q == ST_HICCUP && tmr_bus.cnt == HICCUP_TICKS))
		else $error("short at window end not retried");

	a_window_to_normal: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
		(state_q == ST_RAMP && tmr_bus.done && !out_below_40pct && run_ok && !thermal_trip
		&& !overcurrent_trip) |=> state_q == ST_ON ##2 (prog_q || blank_q != '0))
		else $error("window end did not enter normal limit");

	a_ocp_fast_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
		(state_q == ST_ON && overcurrent_trip && run_ok) |-> ##2 !switch_q ##0 hard_fault_q)
		else $error("overcurrent did not cut switch");

	a_reverse_no_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
		(state_q == ST_REVERSE && !hard_fault_q && !clp_fault_q && !flag_on_q) |=> !flag_on_q)
		else $error("flag raised by reverse block");

	a_flag_immediate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
		$rose(hard_fault_q) |=> (flag_on_q && !flag_lvl_q)) else $error("hard fault flag late");

	a_reverse_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
		(state_q == ST_REVERSE) [*2] |-> !switch_q) else $error("switch on in reverse block");

endmodule // load_switch_seq

// File: rtl/load_switch_regs.svh
`ifndef LOAD_SWITCH_REGS_SVH
`define LOAD_SWITCH_REGS_SVH

// ==================================================
// time base
`define CLK_FREQ_MHZ      50
`define TICK_RATE_MHZ     1
`define TICK_DIV_CYCLES   (`CLK_FREQ_MHZ / `TICK_RATE_MHZ)
`define TICK_W            18

// ==================================================
// sequence times in microseconds, counts in ticks
`define DEB_TIME_US       750
`define FAST_DEB_TIME_US  36
`define RISE_TIME_US      1500
`define FAST_RISE_TIME_US 50
`define SS_TIME_US        7000
`define HICCUP_TIME_US    70000
`define BLANK_TIME_US     370
`define RCP_TIME_US       15
`define FLT_DELAY_TIME_US 8000
`define FLT_RECOV_TIME_US 17000
`define DEB_TICKS         (`DEB_TIME_US * `TICK_RATE_MHZ)
`define FAST_DEB_TICKS    (`FAST_DEB_TIME_US * `TICK_RATE_MHZ)
`define RISE_TICKS        (`RISE_TIME_US * `TICK_RATE_MHZ)
`define FAST_RISE_TICKS   (`FAST_RISE_TIME_US * `TICK_RATE_MHZ)
`define SS_TICKS          (`SS_TIME_US * `TICK_RATE_MHZ)
`define HICCUP_TICKS      (`HICCUP_TIME_US * `TICK_RATE_MHZ)
`define BLANK_TICKS       (`BLANK_TIME_US * `TICK_RATE_MHZ)
`define RCP_TICKS         (`RCP_TIME_US * `TICK_RATE_MHZ)
`define FLT_DELAY_TICKS   (`FLT_DELAY_TIME_US * `TICK_RATE_MHZ)
`define FLT_RECOV_TICKS   (`FLT_RECOV_TIME_US * `TICK_RATE_MHZ)

// ==================================================
// register map
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_HOLD_BIT     0
`define CTRL_RESET        1'h0
`define ST_STATE_LSB      0
`define ST_SWITCH_BIT     4
`define ST_HARD_BIT       5
`define ST_CLP_BIT        6
`define ST_FLAG_BIT       7
`define ST_PIN_BIT        8
`define ST_FAST_BIT       9

`endif

// File: rtl/load_switch_pkg.sv
`include "load_switch_regs.svh"

package load_switch_pkg;

	typedef logic [`TICK_W-1:0] tick_cnt_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_DEBOUNCE,
		ST_RAMP,
		ST_ON,
		ST_REVERSE,
		ST_HICCUP,
		ST_THERMAL,
		ST_SPARE
	} seq_state_t;

endpackage

// File: rtl/timer_if.sv
`timescale 1ns/100ps
`include "load_switch_regs.svh"

interface timer_if;
	logic                load;
	logic [`TICK_W-1:0]  load_val;
	logic                tick;
	logic [`TICK_W-1:0]  cnt;
	logic                done;

	modport ctrl  (output load, output load_val, output tick, input cnt, input done);
	modport timer (input load, input load_val, input tick, output cnt, output done);
endinterface

// File: rtl/seq_timer.sv
`timescale 1ns/100ps

module seq_timer
	import load_switch_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	timer_if.timer   tmr
);

	tick_cnt_t cnt_q;

	// load wins over counting so a new phase never inherits a stale count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (tmr.load) begin
			cnt_q <= tmr.load_val;
		end else if (tmr.tick && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign tmr.cnt  = cnt_q;
	assign tmr.done = (cnt_q == '0);

endmodule // seq_timer

// File: test/power_ctl_model.sv
`timescale 1ns/100ps

// ==========
// system controller: drives enable and fast-on, watches the flag
module power_ctl_model (
	input  wire logic pclk,
	input  wire logic fault_pin,
	output logic      enable,
	output logic      fast_on,
	output logic      fault_seen
);
	// a low pin is a fault; the pull-up holds it high when released
	assign fault_seen = !fault_pin;

	initial begin
		enable  = 1'b0;
		fast_on = 1'b0;
	end

	// mode settles well before enable so it is captured cleanly
	task automatic start(input logic fast);
		@(posedge pclk);
		fast_on <= fast;
		repeat (4) @(posedge pclk);
		enable <= 1'b1;
	endtask

	task automatic stop();
		@(posedge pclk);
		enable <= 1'b0;
	endtask
endmodule // power_ctl_model

// File: test/tb_top.sv
`timescale 1ns/100ps

module tb_top
	import load_switch_pkg::*;
;
	localparam int TK   = 50;
	localparam int DEB  = 8;
	localparam int RISE = 4;
	localparam int SS   = 12;
	localparam int HIC  = 20;
	localparam int BLK  = 60;
	localparam int FD   = 10;
	localparam int FR   = 15;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        enable;
	logic        fast_on;
	logic        lockout;
	logic        below40;
	logic        above_in;
	logic        limit_on;
	logic        oc_trip;
	logic        hot;
	logic        flag_o;
	logic        flag_oe;
	logic        flag_pin;
	logic        fault_seen;
	logic        switch_on;
	logic        ramp_active;
	logic        soft_limit_en;
	logic        prog_limit_en;
	logic        low_power;
	logic [31:0] rd;
	logic        er;
	int          n;
	int          m;
	int          r;
	int          n_mismatch;
	int          checked;

	// ==========
	// design, controller and open-drain pin
	load_switch_seq #(
		.DEB_TICKS      (tick_cnt_t'(DEB)),
		.RISE_TICKS     (tick_cnt_t'(RISE)),
		.SS_TICKS       (tick_cnt_t'(SS)),
		.HICCUP_TICKS   (tick_cnt_t'(HIC)),
		.BLANK_TICKS    (tick_cnt_t'(BLK)),
		.FLT_DELAY_TICKS(tick_cnt_t'(FD)),
		.FLT_RECOV_TICKS(tick_cnt_t'(FR))
	) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enable(enable), .fast_on(fast_on),
		.supply_lockout(lockout), .out_below_40pct(below40), .out_above_in(above_in),
		.limit_active(limit_on), .overcurrent_trip(oc_trip), .thermal_trip(hot),
		.fault_flag_n_i(flag_pin), .fault_flag_n_o(flag_o), .fault_flag_oe(flag_oe),
		.switch_on(switch_on), .ramp_active(ramp_active), .soft_limit_en(soft_limit_en),
		.prog_limit_en(prog_limit_en), .low_power(low_power)
	);

	power_ctl_model ctl (
		.pclk(pclk), .fault_pin(flag_pin), .enable(enable), .fast_on(fast_on),
		.fault_seen(fault_seen)
	);

	// pull-up wins whenever the pin is released
	assign flag_pin = flag_oe ? flag_o : 1'b1;

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// ==========
	// checking and bus tasks
	task automatic report_and_stop();
		$display("checked %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] d, output logic e);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_mismatch++;
			$display("unexpected at %0t: bus answer missing", $time);
			report_and_stop();
		end
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic st(input logic [2:0] e);
		apb(1'b0, 12'h004, 32'h00000000, rd, er);
		check(32'(rd[2:0]), 32'(e));
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return switch_on;
			1: return ramp_active;
			2: return prog_limit_en;
			3: return flag_pin;
			default: return low_power;
		endcase
	endfunction

	// timer loads between ticks, so a count of N lasts N-1 to N ticks, plus pipeline
	function automatic logic in_win(input int c, input int t);
		return c >= (t - 1) * TK && c <= t * TK + 10;
	endfunction

	task automatic wait_lvl(input int k, input logic v, input int lim, output int c);
		c = 0;
		while (pick(k) !== v) begin
			@(posedge pclk);
			c++;
			if (c > lim * TK) begin
				n_mismatch++;
				$display("unexpected at %0t: wait on output %0d ran out", $time, k);
				report_and_stop();
			end
		end
	endtask

	task automatic recover();
		wait_lvl(2, 1'b1, SS + 2, n);
		wait_lvl(3, 1'b1, FR + 2, n);
		check(32'(in_win(n, FR)), 1);
	endtask

	// ==========
	// scenarios
	initial begin
		presetn  = 1'b0;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = 12'h000;
		pwdata   = 32'h00000000;
		lockout  = 1'b0;
		below40  = 1'b0;
		above_in = 1'b0;
		limit_on = 1'b0;
		oc_trip  = 1'b0;
		hot      = 1'b0;
		n_mismatch = 0;
		checked  = 0;
		r = $urandom(19);
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(32'(low_power), 1);
		check(32'(switch_on | flag_oe), 0);
		apb(1'b0, 12'h008, 32'h00000000, rd, er);
		check(32'({er, rd != 0}), 32'h00000002);
		apb(1'b1, 12'h004, 32'h00000007, rd, er);
		st(ST_OFF);
		// normal soft-start
		ctl.start(1'b0);
		wait_lvl(0, 1'b1, DEB + 2, n);
		check(32'(in_win(n, DEB)), 1);
		check(32'({soft_limit_en, prog_limit_en, low_power}), 32'h00000004);
		wait_lvl(1, 1'b0, RISE + 2, n);
		check(32'(in_win(n, RISE)), 1);
		wait_lvl(2, 1'b1, SS, n);
		check(32'(in_win(n, SS - RISE) && !soft_limit_en), 1);
		st(ST_ON);
		// overcurrent while on
		@(posedge pclk);
		oc_trip <= 1'b1;
		@(posedge pclk);
		oc_trip <= 1'b0;
		wait_lvl(0, 1'b0, 1, n);
		check(32'(n <= 3), 1);
		wait_lvl(3, 1'b0, 1, n);
		check(32'(fault_seen && n <= 3), 1);
		wait_lvl(0, 1'b1, HIC + 2, n);
		check(32'(in_win(n, HIC) && soft_limit_en), 1);
		recover();
		// long current-limit regulation
		@(posedge pclk);
		limit_on <= 1'b1;
		wait_lvl(3, 1'b0, FD + 2, n);
		check(32'(in_win(n, FD) && switch_on), 1);
		@(posedge pclk);
		limit_on <= 1'b0;
		wait_lvl(3, 1'b1, FR + 2, n);
		check(32'(in_win(n, FR)), 1);
		// start into a short
		ctl.stop();
		wait_lvl(4, 1'b1, 1, n);
		check(32'(switch_on), 0);
		below40 <= 1'b1;
		ctl.start(1'b0);
		wait_lvl(0, 1'b1, DEB + 2, n);
		wait_lvl(0, 1'b0, SS + 2, n);
		check(32'(in_win(n, SS) && !flag_pin), 1);
		below40 <= 1'b0;
		wait_lvl(0, 1'b1, HIC + 2, n);
		check(32'(in_win(n, HIC)), 1);
		recover();
		// software hold and supply lockout
		apb(1'b1, 12'h000, $urandom() | 32'h00000001, rd, er);
		wait_lvl(0, 1'b0, 1, n);
		check(32'(n <= 3), 1);
		apb(1'b0, 12'h000, 32'h00000000, rd, er);
		check(rd, 1);
		apb(1'b1, 12'h000, 32'h00000000, rd, er);
		wait_lvl(0, 1'b1, DEB + 2, n);
		check(32'(in_win(n, DEB)), 1);
		@(posedge pclk);
		lockout <= 1'b1;
		wait_lvl(4, 1'b1, 1, n);
		check(32'({switch_on, n <= 3}), 1);
		repeat ((DEB + 2) * TK + $urandom_range(9)) @(posedge pclk);
		check(32'(switch_on), 0);
		lockout <= 1'b0;
		wait_lvl(0, 1'b1, DEB + 2, n);
		check(32'(in_win(n, DEB)), 1);
		// fast turn-on with blanking
		ctl.stop();
		wait_lvl(4, 1'b1, 1, n);
		ctl.start(1'b1);
		wait_lvl(0, 1'b1, 40, n);
		check(32'(in_win(n, 36) && n <= 150 * TK), 1);
		check(32'({soft_limit_en, prog_limit_en}), 0);
		wait_lvl(2, 1'b1, BLK, m);
		check(32'(in_win(n + m, BLK)), 1);
		wait_lvl(1, 1'b0, 40, r);
		check(32'(in_win(n + m + r, 86) && m + r <= 100 * TK), 1);
		apb(1'b0, 12'h004, 32'h00000000, rd, er);
		check(32'({rd[9], rd[2:0]}), 32'h0000000B);
		// reverse while on
		@(posedge pclk);
		above_in <= 1'b1;
		wait_lvl(0, 1'b0, 1, n);
		st(ST_REVERSE);
		check(32'(flag_pin), 1);
		above_in <= 1'b0;
		wait_lvl(0, 1'b1, 17, n);
		check(32'(in_win(n, 15)), 1);
		// reverse found at fast start-up
		ctl.stop();
		wait_lvl(4, 1'b1, 1, n);
		above_in <= 1'b1;
		ctl.start(1'b1);
		repeat (40 * TK) @(posedge pclk);
		check(32'({switch_on, flag_pin}), 1);
		st(ST_REVERSE);
		above_in <= 1'b0;
		wait_lvl(0, 1'b1, 17, n);
		check(32'(in_win(n, 15)), 1);
		// thermal shutdown and retry
		@(posedge pclk);
		hot <= 1'b1;
		wait_lvl(0, 1'b0, 1, n);
		wait_lvl(3, 1'b0, 1, m);
		check(32'(n + m <= 4), 1);
		st(ST_THERMAL);
		hot <= 1'b0;
		wait_lvl(0, 1'b1, HIC + 2, n);
		check(32'(in_win(n, HIC) && !flag_pin), 1);
		recover();
		report_and_stop();
	end
endmodule // tb_top
